// *** verilog/sar_adc_serial_readout.sv ***
// Purpose: Conversion control and serial readout of a sampling converter
// Assumes: Host pins are asynchronous; the conversion code comes from
//          the converter core on the core clock
// Notes:   Outputs with enables stand for three-state pins
//
// Summary of operation
// - Select low: device drives bit clock
// - Select high: host supplies bit clock
// - Data pin carries last completed result
// - Internal mode: bit stable over both edges
// - Conversion always timed internally
// - Convert falling edge holds and starts
// - Edges during conversion are ignored
// - Internal mode: shift during conversion
// - Chip select high disables all outputs
// - Busy low for whole conversion
// - Internal transfer fits inside busy low
// - Power down puts logic in low power
// - Sixteen bits, two's complement, MSB first
// - External mode: load just before busy rises
`timescale 1ns/100ps
module sar_adc_serial_readout #(
  parameter int unsigned RESULT_W = sar_readout_pkg::RESULT_BITS
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_nrst,
  // Host control pins
  input wire logic i_convert_start_n,
  input wire logic i_chip_select_n,
  input wire logic i_clock_source_select,
  input wire logic i_power_down_request,
  // Bit clock pin, input half
  input wire logic i_serial_bit_clock,
  // Converter core result
  input wire logic [RESULT_W-1:0] i_convert_start_n_code,
  // Bit clock pin, output half
  output logic o_serial_bit_clock,
  output logic o_serial_bit_clock_oe,
  // Serial data pin
  output logic o_serial_data,
  output logic o_serial_data_oe,
  // Busy pin, low while converting
  output logic o_busy_n,
  output logic o_busy_n_oe,
  // Converter core controls
  output logic o_sample_hold,
  output logic o_low_power
);

  // ---------------------------------------------------------------
  // Derived timing
  // ---------------------------------------------------------------
  localparam int unsigned BUSY_CYC = sar_readout_pkg::FIRST_RISE_CYCLES
    + (RESULT_W - 1) * sar_readout_pkg::BIT_PERIOD_CYCLES
    + sar_readout_pkg::BIT_HIGH_CYCLES + sar_readout_pkg::TAIL_CYCLES;
  localparam int unsigned DONE_CYC = BUSY_CYC - sar_readout_pkg::DONE_TO_BUSY_CYCLES;
  localparam int unsigned CW = sar_readout_pkg::CNT_W;
  localparam int unsigned PW = sar_readout_pkg::PH_W;
  localparam int unsigned BW = sar_readout_pkg::BIT_W;
  localparam logic [CW-1:0] LEAD_LAST = CW'(sar_readout_pkg::FIRST_RISE_CYCLES - 1);
  localparam logic [CW-1:0] DONE_AT = CW'(DONE_CYC);
  localparam logic [CW-1:0] BUSY_LAST = CW'(BUSY_CYC - 1);
  localparam logic [PW-1:0] HIGH_LAST = PW'(sar_readout_pkg::BIT_HIGH_CYCLES - 1);
  localparam logic [PW-1:0] LOW_LAST = PW'(sar_readout_pkg::BIT_LOW_CYCLES - 1);
  localparam logic [PW-1:0] HOLD_AT = PW'(sar_readout_pkg::DATA_HOLD_CYCLES - 1);
  localparam logic [BW-1:0] LAST_BIT = BW'(RESULT_W - 1);

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  if (RESULT_W < 2 || RESULT_W > (1 << BW)) begin : g_width_check
    $error("result width does not fit the bit counter");
  end
  if (BUSY_CYC > sar_readout_pkg::BUSY_MAX_CYCLES || BUSY_CYC >= (1 << CW)) begin : g_busy_check
    $error("serial transfer does not fit in the busy interval");
  end
  if (sar_readout_pkg::DATA_HOLD_CYCLES >= sar_readout_pkg::BIT_LOW_CYCLES) begin : g_hold_check
    $error("data change point falls outside the low phase");
  end

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    sar_readout_pkg::seq_state_e state;
    logic [CW-1:0] cnt;
    logic [PW-1:0] ph;
    logic [BW-1:0] bit_idx;
    logic [RESULT_W-1:0] work;
    logic convert_start_n_prev;
    logic sclk_prev;
    logic clk_out;
    logic clk_oe;
    logic data_oe;
    logic busy_n;
    logic busy_oe;
    logic hold;
    logic low_power;
  } ctrl_s;

  ctrl_s q;
  ctrl_s d;

  logic [sar_readout_pkg::PIN_COUNT-1:0] pins_async;
  logic [sar_readout_pkg::PIN_COUNT-1:0] pins;
  logic convert_start_n_n_s;
  logic cs_n_s;
  logic ext_sel_s;
  logic pdr_s;
  logic sclk_s;
  logic start_edge;
  logic ext_rise;
  logic load_strobe;
  logic shift_strobe;
  logic int_shift;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  // Bundle the asynchronous pins
  always_comb begin
    pins_async = '0;
    pins_async[sar_readout_pkg::PIN_CONVERT_START_N] = i_convert_start_n;
    pins_async[sar_readout_pkg::PIN_CS] = i_chip_select_n;
    pins_async[sar_readout_pkg::PIN_SEL] = i_clock_source_select;
    pins_async[sar_readout_pkg::PIN_PDR] = i_power_down_request;
    pins_async[sar_readout_pkg::PIN_SCLK] = i_serial_bit_clock;
  end

  pin_sync #(
    .WIDTH(sar_readout_pkg::PIN_COUNT),
    .RESET_VALUE(sar_readout_pkg::PIN_RESET)
  ) u_pin_sync (
    .i_core_clk(i_core_clk),
    .i_nrst(i_nrst),
    .i_async(pins_async),
    .o_sync(pins)
  );

  // Unpack the stable levels
  assign convert_start_n_n_s = pins[sar_readout_pkg::PIN_CONVERT_START_N];
  assign cs_n_s = pins[sar_readout_pkg::PIN_CS];
  assign ext_sel_s = pins[sar_readout_pkg::PIN_SEL];
  assign pdr_s = pins[sar_readout_pkg::PIN_PDR];
  assign sclk_s = pins[sar_readout_pkg::PIN_SCLK];

  // ---------------------------------------------------------------
  // Edge detection
  // ---------------------------------------------------------------
  // Falling edge of convert, chip select ignored
  assign start_edge = q.convert_start_n_prev & ~convert_start_n_n_s;

  // Rising edge of host bit clock
  assign ext_rise = ext_sel_s & sclk_s & ~q.sclk_prev;

  // ---------------------------------------------------------------
  // Sequencer and pin control
  // ---------------------------------------------------------------
  // Next state of the sequencer, counters and pin registers
  always_comb begin
    d = q;
    load_strobe = 1'b0;
    int_shift = 1'b0;
    d.convert_start_n_prev = convert_start_n_n_s;
    d.sclk_prev = sclk_s;
    // Power down level drives low power state
    d.low_power = pdr_s;
    // Chip select gates data and busy drivers
    d.data_oe = ~cs_n_s;
    d.busy_oe = ~cs_n_s;
    // Drive bit clock only in internal mode
    d.clk_oe = ~cs_n_s & ~ext_sel_s;

    case (q.state)
      sar_readout_pkg::st_idle: begin
        d.cnt = '0;
        d.ph = '0;
        d.bit_idx = '0;
        d.clk_out = 1'b0;
        if (start_edge && !pdr_s) begin
          d.state = sar_readout_pkg::st_lead;
          d.hold = 1'b1;
          d.busy_n = 1'b0;
        end
      end
      sar_readout_pkg::st_lead: begin
        d.cnt = q.cnt + 1'b1;
        if (q.cnt == LEAD_LAST) begin
          d.state = sar_readout_pkg::st_high;
          d.ph = '0;
          d.clk_out = ~ext_sel_s;
        end
      end
      sar_readout_pkg::st_high: begin
        d.cnt = q.cnt + 1'b1;
        d.ph = q.ph + 1'b1;
        if (q.ph == HIGH_LAST) begin
          d.ph = '0;
          d.clk_out = 1'b0;
          // Last falling edge ends the transfer
          if (q.bit_idx == LAST_BIT) begin
            d.state = sar_readout_pkg::st_tail;
          end else begin
            d.state = sar_readout_pkg::st_low;
          end
        end
      end
      sar_readout_pkg::st_low: begin
        d.cnt = q.cnt + 1'b1;
        d.ph = q.ph + 1'b1;
        // Change data well after the falling edge
        if (q.ph == HOLD_AT) begin
          int_shift = ~ext_sel_s;
        end
        if (q.ph == LOW_LAST) begin
          d.state = sar_readout_pkg::st_high;
          d.ph = '0;
          d.bit_idx = q.bit_idx + 1'b1;
          d.clk_out = ~ext_sel_s;
        end
      end
      sar_readout_pkg::st_tail: begin
        d.cnt = q.cnt + 1'b1;
      end
      default: begin
        d.state = sar_readout_pkg::st_idle;
      end
    endcase

    // Conversion end set by internal count only
    if (q.state != sar_readout_pkg::st_idle && q.cnt == DONE_AT) begin
      d.work = i_convert_start_n_code;
      d.hold = 1'b0;
    end

    // Load result just before busy rises
    if (q.state != sar_readout_pkg::st_idle && q.cnt == BUSY_LAST) begin
      load_strobe = 1'b1;
      d.state = sar_readout_pkg::st_idle;
      d.clk_out = 1'b0;
      d.busy_n = 1'b1;
    end
  end

  // Host clock shifts only in external mode
  assign shift_strobe = int_shift | ext_rise;

  // Register all control state
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      q.state <= sar_readout_pkg::st_idle;
      q.cnt <= '0;
      q.ph <= '0;
      q.bit_idx <= '0;
      q.work <= RESULT_W'(sar_readout_pkg::RESULT_RESET);
      q.convert_start_n_prev <= 1'b0;
      q.sclk_prev <= 1'b0;
      q.clk_out <= 1'b0;
      q.clk_oe <= 1'b0;
      q.data_oe <= 1'b0;
      q.busy_n <= 1'b1;
      q.busy_oe <= 1'b0;
      q.hold <= 1'b0;
      q.low_power <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------
  // Output shift register
  // ---------------------------------------------------------------
  // Shifter holds the last completed result
  result_shifter #(
    .WIDTH(RESULT_W)
  ) u_result_shifter (
    .i_core_clk(i_core_clk),
    .i_nrst(i_nrst),
    .i_load(load_strobe),
    .i_load_value(q.work),
    .i_shift(shift_strobe),
    .o_msb(o_serial_data)
  );

  // ---------------------------------------------------------------
  // Pin outputs
  // ---------------------------------------------------------------
  // Registered pin drivers and enables
  assign o_serial_bit_clock = q.clk_out;
  assign o_serial_bit_clock_oe = q.clk_oe;
  assign o_serial_data_oe = q.data_oe;
  assign o_busy_n = q.busy_n;
  assign o_busy_n_oe = q.busy_oe;
  assign o_sample_hold = q.hold;
  assign o_low_power = q.low_power;

endmodule

// *** pkg/sar_readout_pkg.sv ***
// Purpose: Shared constants and types for the converter serial readout
// Assumes: Core clock of 25 MHz; all times below are in nanoseconds
// Notes:   Cycle counts are derived from the times and the clock period
package sar_readout_pkg;

  // ---------------------------------------------------------------
  // Clock and word format
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned RESULT_BITS = 16;
  localparam logic [15:0] RESULT_RESET = 16'h0000;

  // ---------------------------------------------------------------
  // Timing figures
  // ---------------------------------------------------------------
  localparam int unsigned FIRST_RISE_NS = 1400;
  localparam int unsigned BIT_CLK_HIGH_NS = 350;
  localparam int unsigned BIT_CLK_LOW_NS = 760;
  localparam int unsigned DATA_HOLD_NS = 400;
  localparam int unsigned LAST_FALL_TO_BUSY_NS = 800;
  localparam int unsigned DONE_TO_BUSY_NS = 1100;
  localparam int unsigned BUSY_MAX_NS = 20000;
  localparam int unsigned MIN_START_PERIOD_NS = 25000;

  // ---------------------------------------------------------------
  // Cycle counts (least times round up, longest round down)
  // ---------------------------------------------------------------
  localparam int unsigned FIRST_RISE_CYCLES = (FIRST_RISE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned BIT_HIGH_CYCLES = (BIT_CLK_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned BIT_LOW_CYCLES = (BIT_CLK_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DATA_HOLD_CYCLES = (DATA_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TAIL_CYCLES =
    (LAST_FALL_TO_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DONE_TO_BUSY_CYCLES =
    (DONE_TO_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned BUSY_MAX_CYCLES = BUSY_MAX_NS / CLK_PERIOD_NS;
  localparam int unsigned BIT_PERIOD_CYCLES = BIT_HIGH_CYCLES + BIT_LOW_CYCLES;

  // ---------------------------------------------------------------
  // Counter widths
  // ---------------------------------------------------------------
  localparam int unsigned CNT_W = 9;
  localparam int unsigned PH_W = 5;
  localparam int unsigned BIT_W = 4;

  // ---------------------------------------------------------------
  // Pin synchroniser bundle: {convert_start_n, cs, sel, pdr, sclk}
  // ---------------------------------------------------------------
  localparam int unsigned PIN_COUNT = 5;
  localparam logic [4:0] PIN_RESET = 5'h08;
  localparam int unsigned PIN_CONVERT_START_N = 4;
  localparam int unsigned PIN_CS = 3;
  localparam int unsigned PIN_SEL = 2;
  localparam int unsigned PIN_PDR = 1;
  localparam int unsigned PIN_SCLK = 0;

  // Conversion and bit clock sequencer
  typedef enum logic [2:0] {
    st_idle,
    st_lead,
    st_high,
    st_low,
    st_tail
  } seq_state_e;

endpackage

// *** verilog/pin_sync.sv ***
// Purpose: Two-flop synchroniser for a group of asynchronous pins
// Assumes: Each bit is an independent level
// Notes:   First stage is read only by the second stage
`timescale 1ns/100ps
module pin_sync #(
  parameter int unsigned WIDTH = 5,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_nrst,
  // Pins
  input wire logic [WIDTH-1:0] i_async,
  // Synchronised levels
  output logic [WIDTH-1:0] o_sync
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_s;

  sync_s q;
  sync_s d;

  // Refuse an empty group
  if (WIDTH < 1) begin : g_check
    $error("pin_sync width must be at least one");
  end

  // Next stage values, one bit per pin
  always_comb begin
    d = q;
    for (int i = 0; i < WIDTH; i++) begin
      d.meta[i] = i_async[i];
      d.stable[i] = q.meta[i];
    end
  end

  // Register both stages
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      q <= {RESET_VALUE, RESET_VALUE};
    end else begin
      q <= d;
    end
  end

  assign o_sync = q.stable;

endmodule

// *** verilog/result_shifter.sv ***
// Purpose: Output shift register for the serial result, MSB first
// Assumes: Load and shift are one-cycle strobes on the core clock
// Notes:   Load wins over shift; zeros fill from the bottom
`timescale 1ns/100ps
module result_shifter #(
  parameter int unsigned WIDTH = 16
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_nrst,
  // Control strobes
  input wire logic i_load,
  input wire logic [WIDTH-1:0] i_load_value,
  input wire logic i_shift,
  // Serial bit, straight from the register
  output logic o_msb
);

  typedef struct packed {
    logic [WIDTH-1:0] sreg;
  } shift_s;

  shift_s q;
  shift_s d;

  // Refuse a word too short to shift
  if (WIDTH < 2) begin : g_check
    $error("result_shifter width must be at least two");
  end

  // Load or advance one bit
  always_comb begin
    d = q;
    if (i_load) begin
      d.sreg = i_load_value;
    end else if (i_shift) begin
      d.sreg = {q.sreg[WIDTH-2:0], 1'b0};
    end
  end

  // Register the word
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_msb = q.sreg[WIDTH-1];

endmodule

// *** verif/sar_readout_sva.sv ***
// Purpose: Port-level checks of the converter readout
// Assumes: Clock select and chip select stay steady during a conversion
// Notes:   Bound to the top module
`timescale 1ns/100ps
module sar_readout_sva #(
  parameter int unsigned RESULT_W = 16
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_nrst,
  // Host pins
  input wire logic i_chip_select_n,
  input wire logic i_clock_source_select,
  input wire logic i_power_down_request,
  // Design outputs
  input wire logic o_serial_bit_clock,
  input wire logic o_serial_bit_clock_oe,
  input wire logic o_serial_data,
  input wire logic o_serial_data_oe,
  input wire logic o_busy_n,
  input wire logic o_busy_n_oe,
  input wire logic o_sample_hold,
  input wire logic o_low_power
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);

  logic [9:0] low_cnt_q;
  logic [4:0] rise_cnt_q;
  logic clk_q;
  logic [4:0] high_cnt_q;

  // Counts busy-low cycles and bit clock rises per conversion
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst || o_busy_n) begin
      low_cnt_q <= '0;
      rise_cnt_q <= '0;
    end else begin
      low_cnt_q <= low_cnt_q + 10'h001;
      rise_cnt_q <= rise_cnt_q + 5'(o_serial_bit_clock && !clk_q);
    end
    clk_q <= i_nrst && o_serial_bit_clock;
  end

  // Counts consecutive high cycles of the bit clock
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst || !o_serial_bit_clock) begin
      high_cnt_q <= '0;
    end else begin
      high_cnt_q <= high_cnt_q + 5'h01;
    end
  end

  // ----------
  // Assertions
  // ----------
  a_busy_len: assert property ($rose(o_busy_n) |-> low_cnt_q == 10'h1e4)
    else $error("busy low length wrong");
  a_hold_start: assert property ($fell(o_busy_n) |-> o_sample_hold)
    else $error("hold missing at start");
  a_hold_len: assert property ($fell(o_sample_hold) |-> low_cnt_q == 10'h1c9)
    else $error("hold length wrong");
  a_clk_high_time: assert property ($fell(o_serial_bit_clock) |-> high_cnt_q == 5'h09)
    else $error("bit clock high time wrong");
  a_clk_in_busy: assert property (o_serial_bit_clock |-> !o_busy_n)
    else $error("bit clock outside busy");
  a_data_both_edges: assert property (
    (o_serial_bit_clock || $fell(o_serial_bit_clock)) |-> $stable(o_serial_data))
    else $error("data moved near clock edge");
  a_rise_count: assert property ($rose(o_busy_n) && !i_clock_source_select
    && !i_chip_select_n |-> rise_cnt_q == RESULT_W)
    else $error("bit clock rise count wrong");
  a_ext_no_drive: assert property (i_clock_source_select[*4] |-> !o_serial_bit_clock_oe)
    else $error("bit clock driven in external mode");
  a_oe_off: assert property ($rose(i_chip_select_n) |-> ##3
    !(o_serial_data_oe || o_busy_n_oe || o_serial_bit_clock_oe))
    else $error("outputs not released");
  a_oe_on: assert property ($fell(i_chip_select_n) |-> ##3
    o_serial_data_oe && o_busy_n_oe)
    else $error("outputs not enabled");
  a_low_power: assert property ($stable(i_power_down_request)[*4] |->
    o_low_power == i_power_down_request)
    else $error("low power level wrong");

  // Main scenarios reached
  c_int_word: cover property ($rose(o_busy_n) && rise_cnt_q == RESULT_W);
  c_ext_convert_start_n: cover property ($fell(o_busy_n) && i_clock_source_select);
  c_low_power: cover property ($rose(o_low_power));
endmodule

bind sar_adc_serial_readout sar_readout_sva #(.RESULT_W(RESULT_W)) u_sva (
  .i_core_clk, .i_nrst, .i_chip_select_n, .i_clock_source_select, .i_power_down_request,
  .o_serial_bit_clock, .o_serial_bit_clock_oe, .o_serial_data, .o_serial_data_oe,
  .o_busy_n, .o_busy_n_oe, .o_sample_hold, .o_low_power);

// *** verif/sar_host_model.sv ***
// Purpose: Behavioural host that starts conversions and reads results
// Assumes: Tasks are entered just after a clock edge
// Notes:   External bit clock stays low outside reads
`timescale 1ns/100ps
module sar_host_model (
  // Clock
  input wire logic i_core_clk,
  // Pins from the converter
  input wire logic i_busy_n,
  input wire logic i_serial_data,
  // Pins to the converter
  output logic o_convert_start_n,
  output logic o_serial_bit_clock
);
  int unsigned cyc = 0;
  int unsigned last_start = 0;

  // Cycle count for start spacing
  always @(posedge i_core_clk) cyc <= cyc + 1;

  initial begin
    o_convert_start_n = 1'b1;
    o_serial_bit_clock = 1'b0;
  end

  task automatic tick(input int unsigned n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask

  task automatic set_convert_start_n(input logic v);
    o_convert_start_n = v;
  endtask

  // Short low pulse on the convert pin
  task automatic pulse_convert_start_n();
    o_convert_start_n = 1'b0;
    tick(2);
    o_convert_start_n = 1'b1;
  endtask

  task automatic start();
    while (cyc < last_start + 630) tick(1);
    last_start = cyc;
    pulse_convert_start_n();
  endtask

  task automatic clock_once(input int unsigned half);
    o_serial_bit_clock = 1'b1;
    tick(half);
    o_serial_bit_clock = 1'b0;
    tick(half);
  endtask

  task automatic read_ext(input int unsigned half, output logic [15:0] word);
    for (int n = 0; n < 700 && i_busy_n !== 1'b1; n++) tick(1);
    for (int i = 15; i >= 0; i--) begin
      word[i] = i_serial_data;
      if (i > 0) clock_once(half);
    end
  endtask
endmodule

// *** verif/sar_adc_serial_readout_bench.sv ***
// Purpose: Self-checking bench of the converter readout
// Assumes: Host model owns the convert and external bit clock pins
// Notes:   Expected words come from a queue of finished codes
`timescale 1ns/100ps
module sar_adc_serial_readout_bench;
  logic i_core_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic i_chip_select_n = 1'b0;
  logic i_clock_source_select = 1'b0;
  logic i_power_down_request = 1'b0;
  logic [15:0] i_convert_start_n_code = 16'h0000;
  logic i_convert_start_n, host_clk, i_serial_bit_clock, data_pin, busy_pin;
  logic o_serial_bit_clock, o_serial_bit_clock_oe, o_serial_data, o_serial_data_oe;
  logic o_busy_n, o_busy_n_oe, o_sample_hold, o_low_power;
  logic [15:0] word;
  int done_q[$] = '{0};
  int fails = 0;
  int num_checks = 0;

  // ----------
  // Design, host and pins
  // ----------
  sar_adc_serial_readout u_dut (
    .i_core_clk, .i_nrst, .i_convert_start_n, .i_chip_select_n, .i_clock_source_select,
    .i_power_down_request, .i_serial_bit_clock, .i_convert_start_n_code, .o_serial_bit_clock,
    .o_serial_bit_clock_oe, .o_serial_data, .o_serial_data_oe, .o_busy_n, .o_busy_n_oe,
    .o_sample_hold, .o_low_power);
  sar_host_model u_host (.i_core_clk, .i_busy_n(busy_pin), .i_serial_data(data_pin),
    .o_convert_start_n(i_convert_start_n), .o_serial_bit_clock(host_clk));

  // Released data and busy pins show the inverse of their last value; the released bit clock pin takes the host clock
  assign i_serial_bit_clock = o_serial_bit_clock_oe ? o_serial_bit_clock : host_clk;
  assign data_pin = o_serial_data_oe ? o_serial_data : ~o_serial_data;
  assign busy_pin = o_busy_n_oe ? o_busy_n : ~o_busy_n;

  initial forever #20 i_core_clk = ~i_core_clk;

  task automatic tick(input int unsigned n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] want, input string what);
    num_checks++;
    if (seen !== want) begin
      fails++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask

  task automatic conclude();
    $display("checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // One conversion, collecting internal-mode bits at each clock rise
  task automatic run_convert_start_n(input logic [15:0] code, input bit glitch);
    logic [15:0] w;
    int low;
    int rises;
    logic prev;
    w = '0;
    low = 0;
    rises = 0;
    prev = 1'b0;
    i_convert_start_n_code = code;
    u_host.start();
    for (int n = 0; n < 20 && o_busy_n !== 1'b0; n++) tick(1);
    while (o_busy_n === 1'b0 && low < 600) begin
      if (o_serial_bit_clock === 1'b1 && prev === 1'b0) begin
        w = {w[14:0], o_serial_data};
        rises++;
      end
      prev = o_serial_bit_clock;
      if (glitch && low == 100) fork u_host.pulse_convert_start_n(); join_none
      low++;
      tick(1);
    end
    check(16'(low), 16'h01e4, "busy low length");
    if (i_clock_source_select) check(16'(rises), 16'h0000, "device clocked");
    else check(w, 16'(done_q[$]), "internal word");
    done_q.push_back(int'(code));
    check(16'(o_serial_data), 16'(code[15]), "msb after busy");
  endtask

  initial begin
    #2000000;
    fails++;
    conclude();
  end

  initial begin
    void'($urandom(32'he7324299));
    tick(20);
    check(16'({o_serial_bit_clock_oe, o_serial_data_oe, o_busy_n_oe, o_busy_n}),
      16'h0001, "reset outputs");
    i_nrst = 1'b1;
    tick(4);
    check(16'({o_serial_bit_clock_oe, o_serial_data_oe, o_busy_n_oe}), 16'h0007,
      "outputs enabled");
    run_convert_start_n(16'h8000, 1'b0);
    run_convert_start_n(16'h7fff, 1'b0);
    run_convert_start_n(16'($urandom), 1'b0);
    // External bit clock, prompt and slow reads
    i_clock_source_select = 1'b1;
    tick(4);
    check(16'(o_serial_bit_clock_oe), 16'h0000, "clock pin driven");
    run_convert_start_n(16'($urandom), 1'b1);
    u_host.read_ext(3, word);
    check(word, 16'(done_q[$]), "fast external read");
    run_convert_start_n(16'hffff, 1'b0);
    u_host.read_ext(20, word);
    check(word, 16'(done_q[$]), "slow external read");
    u_host.clock_once(3);
    check(16'(data_pin), 16'h0000, "zero fill");
    // Conversion with chip select high
    i_clock_source_select = 1'b0;
    i_chip_select_n = 1'b1;
    i_convert_start_n_code = 16'($urandom);
    tick(4);
    check(16'({o_serial_bit_clock_oe, o_serial_data_oe, o_busy_n_oe}), 16'h0000,
      "outputs released");
    u_host.start();
    tick(2);
    check(16'(o_sample_hold), 16'h0001, "start with chip select high");
    tick(500);
    done_q.push_back(int'(i_convert_start_n_code));
    i_chip_select_n = 1'b0;
    // Power down refuses starts
    i_power_down_request = 1'b1;
    tick(4);
    check(16'(o_low_power), 16'h0001, "low power entered");
    u_host.start();
    tick(3);
    check(16'(o_sample_hold), 16'h0000, "start in power down");
    // convert low before leaving power down
    u_host.set_convert_start_n(1'b0);
    tick(2);
    i_power_down_request = 1'b0;
    tick(4);
    check(16'({o_low_power, o_sample_hold}), 16'h0000, "power down left");
    u_host.set_convert_start_n(1'b1);
    run_convert_start_n(16'($urandom), 1'b0);
    conclude();
  end
endmodule
